// ### hw/xgp_regs.svh
// Purpose: register offsets, fields and reset values of the external port
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef XGP_REGS_SVH
`define XGP_REGS_SVH
`define XGP_CFG_OFF 12'h000
`define XGP_MAP_OFF 12'h004
`define XGP_RDADDR_OFF 12'h008
`define XGP_RDCNT_OFF 12'h00C
`define XGP_RDCTL_OFF 12'h010
`define XGP_RDDATA_OFF 12'h014
`define XGP_STAT_OFF 12'h018
`define XGP_WRDATA_OFF 12'h01C
`define XGP_WRADDR_OFF 12'h020
`define XGP_FIFOCFG_OFF 12'h024
`define XGP_ERR_OFF 12'h028
`define XGP_CFG_RST 32'h0000_0000
`define XGP_MAP_RST 8'h00
`define XGP_FIFOCFG_RST 8'h00
// config fields
`define XGP_CFG_CLKPIN 0
`define XGP_CFG_CLKGATE 1
`define XGP_CFG_RDYEN 2
`define XGP_CFG_FRAMEPIN 3
`define XGP_CFG_FRAME50 4
`define XGP_CFG_RDWR 5
`define XGP_CFG_WR2 6
`define XGP_CFG_RD2 7
`define XGP_CFG_ASIZE_LO 8
`define XGP_CFG_DSIZE_LO 10
`define XGP_CFG_WORD 12
`define XGP_CFG_CLKENA 13
`define XGP_CFG_FRAME_LO 16
`define XGP_CFG_WAIT_LO 24
// fifo config fields
`define XGP_FC_WRERR 0
`define XGP_FC_RDERR 1
`define XGP_FC_TXTRIG_LO 2
`define XGP_FC_RXTRIG_LO 4
// error bits
`define XGP_ERR_TIMEOUT 0
`define XGP_ERR_WRFULL 1
`define XGP_ERR_RDSTALL 2
`define XGP_WBUF_DEPTH 4
`define XGP_RFIFO_DEPTH 8
// interface clock: system clock divided by 8 (fixed)
`define XGP_LCLK_HALF 4
`endif

// ### hw/xgp_pkg.sv
// Purpose: types shared by the external port files
// Assumes: nothing
// Notes: no constants here, see xgp_regs.svh
package xgp_pkg;
  typedef enum logic [2:0] {
    XGP_IDLE = 3'b000,
    XGP_SETUP = 3'b001,
    XGP_STROBE = 3'b011,
    XGP_SECOND = 3'b010,
    XGP_DONE = 3'b110
  } xgp_state_t;
  typedef struct packed {
    logic is_read;
    logic [31:0] addr;
    logic [31:0] data;
  } xgp_txn_t;
endpackage

// ### hw/xgp_wbuf.sv
// Purpose: four-entry pending write buffer
// Assumes: same clock as the port core
// Notes: space output tells software how many writes go without stall
`timescale 1ns/100ps
`default_nettype none
`include "xgp_regs.svh"
module xgp_wbuf (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic push,
  input wire logic [63:0] push_data,
  input wire logic pop,
  output logic [63:0] head,
  output logic empty,
  output logic full,
  output logic [2:0] space
);
  logic [63:0] mem_q [0:3];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] cnt_q;
  assign empty = (cnt_q == 3'h0);
  assign full = (cnt_q == 3'h4);
  assign space = 3'h4 - cnt_q;
  assign head = mem_q[rp_q];
  always_ff @(posedge aclk) begin
    if (ce && push && !full) begin
      mem_q[wp_q] <= push_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end else if (ce) begin
      if (push && !full) begin
        wp_q <= wp_q + 2'h1;
      end
      if (pop && !empty) begin
        rp_q <= rp_q + 2'h1;
      end
      cnt_q <= cnt_q + {2'h0, push && !full} - {2'h0, pop && !empty};
    end
  end
endmodule
`default_nettype wire

// ### hw/xgp_rfifo.sv
// Purpose: read FIFO for streaming reads
// Assumes: same clock as the port core
// Notes: level output is the count readable without stalling
`timescale 1ns/100ps
`default_nettype none
`include "xgp_regs.svh"
module xgp_rfifo (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] head,
  output logic empty,
  output logic full,
  output logic [3:0] level
);
  logic [31:0] mem_q [0:7];
  logic [2:0] wp_q;
  logic [2:0] rp_q;
  logic [3:0] cnt_q;
  assign empty = (cnt_q == 4'h0);
  assign full = (cnt_q == 4'h8);
  assign level = cnt_q;
  assign head = mem_q[rp_q];
  always_ff @(posedge aclk) begin
    if (ce && push && !full) begin
      mem_q[wp_q] <= push_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && flush)) begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end else if (ce) begin
      if (push && !full) begin
        wp_q <= wp_q + 3'h1;
      end
      if (pop && !empty) begin
        rp_q <= rp_q + 3'h1;
      end
      cnt_q <= cnt_q + {3'h0, push && !full} - {3'h0, pop && !empty};
    end
  end
endmodule
`default_nettype wire

// ### hw/xgp_port.sv
// Purpose: general-purpose external bus port with AXI4-Lite registers
// Assumes: aclk 100 MHz; interface clock fixed at aclk/8
// Notes: window hits arrive on the map_* request port
//
// How it works
// - up to four writes queue; fifth stalls; free slots readable.
// - read engine fetches sequential addresses into the read FIFO.
// - streaming starts on software start, halts on software stop.
// - remaining item count of the stream is readable.
// - read FIFO level readable as items available now.
// - FIFO data popped as 32, 16 or 8 bit items.
// - trigger levels programmable; optional error on write or read stall.
// - each window sized 256B, 64KB, 16MB or 512MB.
// - peripheral base none/A0/C0, RAM base none/60/80.
// - interface clock optionally driven on its own pin.
// - gated clock stops when idle, otherwise runs freely.
// - ready input honoured when enabled, else always ready.
// - ready option ignored while clock gating is selected.
// - frame pin as half-duty wave or pulse when enabled.
// - frame length 0 to 15 clocks, ignored when framing off.
// - separate read and write strobes driven when selected.
// - reads and writes each optionally take two interface cycles.
// - address bus absent, 4, 12 or 20 bits.
// - data bus 8, 16, 24 or 32 bits.
// - word access steers bytes onto their lanes.
// - hold-off limit 0-255 clocks, zero forever, overrun aborts.
`timescale 1ns/100ps
`default_nettype none
`include "xgp_regs.svh"
module xgp_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] map_addr,
  input wire logic map_valid,
  output logic map_hit,
  output logic [19:0] ext_addr,
  output logic [31:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [31:0] ext_data_in,
  output logic ext_clk,
  output logic ext_frame,
  output logic ext_wr_strobe,
  output logic ext_rd_strobe,
  input wire logic peripheral_ready_in,
  input wire logic ext_clock_enable_in,
  output logic error_irq
);
  xgp_pkg::xgp_state_t st_q;
  logic [31:0] cfg_q;
  logic [7:0] map_q;
  logic [7:0] fcfg_q;
  logic [31:0] rd_addr_q;
  logic [15:0] rd_cnt_q;
  logic rd_run_q;
  logic [1:0] rd_size_q;
  logic [2:0] err_q;
  logic aw_q, w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [1:0] rdy_s_q, cke_s_q;
  logic [31:0] din_s1_q, din_s2_q;
  logic [2:0] div_q;
  logic lclk_q;
  logic [3:0] frm_q;
  logic [7:0] wait_q;
  logic cyc2_q;
  xgp_pkg::xgp_txn_t cur_q;
  logic [63:0] wb_head;
  logic wb_empty, wb_full, wb_push, wb_pop;
  logic [2:0] wb_space;
  logic [31:0] rf_head;
  logic rf_empty, rf_full, rf_pop, rf_push, rf_flush;
  logic [3:0] rf_level;
  logic wr_go, rd_go, lrise, ready_ok, busy, timeout;
  function automatic logic [31:0] win_mask(input logic [1:0] sz);
    case (sz)
      2'h0: win_mask = 32'h0000_00FF;
      2'h1: win_mask = 32'h0000_FFFF;
      2'h2: win_mask = 32'h00FF_FFFF;
      default: win_mask = 32'h1FFF_FFFF;
    endcase
  endfunction
  // base address choice, zero means disabled
  function automatic logic [31:0] win_base(input logic [1:0] b,
                                           input logic ram);
    case (b)
      2'h1: win_base = ram ? 32'h6000_0000 : 32'hA000_0000;
      2'h2: win_base = ram ? 32'h8000_0000 : 32'hC000_0000;
      default: win_base = 32'h0000_0000;
    endcase
  endfunction
  function automatic logic win_hit(input logic [31:0] a,
                                   input logic [3:0] f, input logic ram);
    logic [31:0] b;
    b = win_base(f[3:2], ram);
    win_hit = (b != 32'h0) && ((a & ~win_mask(f[1:0])) == b);
  endfunction
  // map_q: [1:0] per size, [3:2] per base, [5:4] ram size, [7:6] ram base
  assign map_hit = map_valid &&
    (win_hit(map_addr, map_q[3:0], 1'b0) ||
     win_hit(map_addr, map_q[7:4], 1'b1));

  xgp_wbuf u_wbuf (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(clk_en),
    .push(wb_push),
    .push_data({wr_addr_q, wdata_q}),
    .pop(wb_pop),
    .head(wb_head),
    .empty(wb_empty),
    .full(wb_full),
    .space(wb_space)
  );
  xgp_rfifo u_rfifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(clk_en),
    .flush(rf_flush),
    .push(rf_push),
    .push_data(cur_q.data),
    .pop(rf_pop),
    .head(rf_head),
    .empty(rf_empty),
    .full(rf_full),
    .level(rf_level)
  );

  // pins from another domain pass two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_s_q <= 2'h0;
      cke_s_q <= 2'h0;
      din_s1_q <= 32'h0000_0000;
      din_s2_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdy_s_q <= {rdy_s_q[0], peripheral_ready_in};
      cke_s_q <= {cke_s_q[0], ext_clock_enable_in};
      din_s1_q <= ext_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // AXI write path: address and data in either order
  logic wr_fire;
  logic [11:0] wa;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wa = awaddr_q;
  // data writes stall (no response) while buffer full
  assign wr_fire = aw_q && w_q && !s_axi_bvalid &&
    !(wa == `XGP_WRDATA_OFF && wb_full);
  assign wb_push = wr_fire && wa == `XGP_WRDATA_OFF;
  assign s_axi_bresp = 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; wstrb ignored, full words only
  logic stop_req, start_req;
  assign start_req = wr_fire && wa == `XGP_RDCTL_OFF && wdata_q[0];
  assign stop_req = wr_fire && wa == `XGP_RDCTL_OFF && wdata_q[1];
  assign rf_flush = start_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `XGP_CFG_RST;
      map_q <= `XGP_MAP_RST;
      fcfg_q <= `XGP_FIFOCFG_RST;
      wr_addr_q <= 32'h0000_0000;
      rd_size_q <= 2'h0;
    end else if (clk_en && wr_fire) begin
      case (wa)
        `XGP_CFG_OFF: cfg_q <= wdata_q;
        `XGP_MAP_OFF: map_q <= wdata_q[7:0];
        `XGP_FIFOCFG_OFF: fcfg_q <= wdata_q[7:0];
        `XGP_WRADDR_OFF: wr_addr_q <= wdata_q;
        `XGP_RDCTL_OFF: rd_size_q <= wdata_q[5:4];
        default: ;
      endcase
    end
  end

  // AXI read path; rdata from flops
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;
  assign s_axi_rdata = rdata_q;
  // pop one item per data read, sized by rd_size_q
  assign rf_pop = s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `XGP_RDDATA_OFF;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `XGP_CFG_OFF: rd_mux = cfg_q;
      `XGP_MAP_OFF: rd_mux = {24'h0, map_q};
      `XGP_RDADDR_OFF: rd_mux = rd_addr_q;
      `XGP_RDCNT_OFF: rd_mux = {16'h0, rd_cnt_q};
      `XGP_RDCTL_OFF: rd_mux = {26'h0, rd_size_q, 3'h0, rd_run_q};
      `XGP_RDDATA_OFF: begin
        case (rd_size_q)
          2'h1: rd_mux = {16'h0, rf_head[15:0]};
          2'h2: rd_mux = {24'h0, rf_head[7:0]};
          default: rd_mux = rf_head;
        endcase
      end
      `XGP_STAT_OFF: rd_mux = {20'h0, rf_level, 5'h0, wb_space};
      `XGP_FIFOCFG_OFF: rd_mux = {24'h0, fcfg_q};
      `XGP_WRADDR_OFF: rd_mux = wr_addr_q;
      `XGP_ERR_OFF: rd_mux = {29'h0, err_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        rdata_q <= rd_mux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // interface clock from divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
      lclk_q <= 1'b0;
    end else if (clk_en) begin
      // gated clock parks low while idle
      // restarts as soon as a transaction is pending
      if (cfg_q[`XGP_CFG_CLKGATE] && !busy && st_q == xgp_pkg::XGP_IDLE) begin
        div_q <= 3'h0;
        lclk_q <= 1'b0;
      end else if (div_q == 3'(`XGP_LCLK_HALF - 1)) begin
        div_q <= 3'h0;
        lclk_q <= !lclk_q;
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end
  assign lrise = !lclk_q && div_q == 3'(`XGP_LCLK_HALF - 1);
  // clock driven out only when selected
  assign ext_clk = cfg_q[`XGP_CFG_CLKPIN] & lclk_q;

  // ready honoured only with free-running clock
  assign ready_ok = !(cfg_q[`XGP_CFG_RDYEN] && !cfg_q[`XGP_CFG_CLKGATE])
    || rdy_s_q[1];
  // external clock enable holds off the bus
  logic held;
  assign held = cfg_q[`XGP_CFG_CLKENA] && !cke_s_q[1];
  assign timeout = held && cfg_q[`XGP_CFG_WAIT_LO +: 8] != 8'h00 &&
    wait_q == cfg_q[`XGP_CFG_WAIT_LO +: 8];
  // writes have priority over stream reads
  assign wr_go = !wb_empty;
  // stream read issued while running and FIFO has room
  assign rd_go = rd_run_q && rd_cnt_q != 16'h0 && !rf_full;
  assign busy = wr_go || rd_go;
  assign wb_pop = lrise && st_q == xgp_pkg::XGP_IDLE && wr_go;
  assign rf_push = lrise && st_q == xgp_pkg::XGP_DONE && cur_q.is_read;

  // byte lane steering for word access
  function automatic logic [31:0] lane(input logic [31:0] d,
                                       input logic [1:0] a, input logic en);
    lane = en ? (d << {a, 3'h0}) : d;
  endfunction
  function automatic logic [31:0] dmask(input logic [1:0] ds);
    case (ds)
      2'h0: dmask = 32'h0000_00FF;
      2'h1: dmask = 32'h0000_FFFF;
      2'h2: dmask = 32'h00FF_FFFF;
      default: dmask = 32'hFFFF_FFFF;
    endcase
  endfunction

  // bus cycle engine stepping on interface clock rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= xgp_pkg::XGP_IDLE;
      cur_q <= '0;
      wait_q <= 8'h00;
      cyc2_q <= 1'b0;
    end else if (clk_en && lrise) begin
      case (st_q)
        xgp_pkg::XGP_IDLE: begin
          wait_q <= 8'h00;
          if (wr_go) begin
            cur_q <= '{is_read: 1'b0, addr: wb_head[63:32],
                       data: wb_head[31:0]};
            st_q <= xgp_pkg::XGP_SETUP;
          end else if (rd_go) begin
            cur_q <= '{is_read: 1'b1, addr: rd_addr_q, data: 32'h0};
            st_q <= xgp_pkg::XGP_SETUP;
          end
        end
        xgp_pkg::XGP_SETUP: begin
          if (timeout) begin
            st_q <= xgp_pkg::XGP_IDLE;
          end else if (held) begin
            wait_q <= wait_q + 8'h01;
          end else begin
            cyc2_q <= cur_q.is_read ? cfg_q[`XGP_CFG_RD2] :
                      cfg_q[`XGP_CFG_WR2];
            st_q <= xgp_pkg::XGP_STROBE;
          end
        end
        xgp_pkg::XGP_STROBE: begin
          if (ready_ok) begin
            st_q <= cyc2_q ? xgp_pkg::XGP_SECOND : xgp_pkg::XGP_DONE;
            cur_q.data <= cur_q.is_read ?
              (din_s2_q & dmask(cfg_q[`XGP_CFG_DSIZE_LO +: 2])) :
              cur_q.data;
          end
        end
        xgp_pkg::XGP_SECOND: st_q <= xgp_pkg::XGP_DONE;
        xgp_pkg::XGP_DONE: st_q <= xgp_pkg::XGP_IDLE;
        default: st_q <= xgp_pkg::XGP_IDLE;
      endcase
    end
  end

  // stream start and stop; address advances per item
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_run_q <= 1'b0;
      rd_cnt_q <= 16'h0000;
      rd_addr_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (stop_req) begin
        rd_run_q <= 1'b0;
      end else if (start_req) begin
        rd_run_q <= 1'b1;
        rd_cnt_q <= wdata_q[31:16];
      end else if (wr_fire && wa == `XGP_RDADDR_OFF) begin
        rd_addr_q <= wdata_q;
      end else if (rf_push) begin
        rd_addr_q <= rd_addr_q + 32'h1;
        rd_cnt_q <= rd_cnt_q - 16'h1;
        if (rd_cnt_q == 16'h1) begin
          rd_run_q <= 1'b0;
        end
      end
    end
  end

  // sticky errors; set beats software clear
  logic [2:0] err_set;
  assign err_set = {
    fcfg_q[`XGP_FC_RDERR] && rd_run_q && wr_go && rd_cnt_q != 16'h0,
    fcfg_q[`XGP_FC_WRERR] && aw_q && w_q && wa == `XGP_WRDATA_OFF &&
      wb_full,
    clk_en && lrise && st_q == xgp_pkg::XGP_SETUP && timeout};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 3'h0;
    end else if (clk_en) begin
      if (wr_fire && wa == `XGP_ERR_OFF) begin
        err_q <= (err_q & ~wdata_q[2:0]) | err_set;
      end else begin
        err_q <= err_q | err_set;
      end
    end
  end
  // error line combines sticky errors and trigger levels
  assign error_irq = (err_q != 3'h0) ||
    (fcfg_q[`XGP_FC_RXTRIG_LO +: 2] != 2'h0 &&
     rf_level >= {fcfg_q[`XGP_FC_RXTRIG_LO +: 2], 2'h0}) ||
    (fcfg_q[`XGP_FC_TXTRIG_LO +: 2] != 2'h0 &&
     wb_space >= {1'b0, fcfg_q[`XGP_FC_TXTRIG_LO +: 2]});

  // frame length counter, ignored without framing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frm_q <= 4'h0;
      ext_frame <= 1'b0;
    end else if (clk_en && lrise) begin
      if (!cfg_q[`XGP_CFG_FRAMEPIN]) begin
        frm_q <= 4'h0;
        ext_frame <= 1'b0;
      end else if (st_q == xgp_pkg::XGP_SETUP && !held) begin
        frm_q <= cfg_q[`XGP_CFG_FRAME_LO +: 4];
        ext_frame <= 1'b1;
      end else if (frm_q != 4'h0) begin
        frm_q <= frm_q - 4'h1;
        // pulse lasts one interface clock, half-duty the whole count
        if (!cfg_q[`XGP_CFG_FRAME50] || frm_q == 4'h1) begin
          ext_frame <= 1'b0;
        end
      end else begin
        ext_frame <= 1'b0;
      end
    end
  end

  // pins from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr <= 20'h00000;
      ext_data_out <= 32'h0000_0000;
      ext_data_oe <= 1'b0;
      ext_wr_strobe <= 1'b0;
      ext_rd_strobe <= 1'b0;
    end else if (clk_en) begin
      // address width 0, 4, 12 or 20
      case (cfg_q[`XGP_CFG_ASIZE_LO +: 2])
        2'h1: ext_addr <= {16'h0, cur_q.addr[3:0]};
        2'h2: ext_addr <= {8'h0, cur_q.addr[11:0]};
        2'h3: ext_addr <= cur_q.addr[19:0];
        default: ext_addr <= 20'h00000;
      endcase
      ext_data_out <= lane(cur_q.data, cur_q.addr[1:0],
        cfg_q[`XGP_CFG_WORD]) & dmask(cfg_q[`XGP_CFG_DSIZE_LO +: 2]);
      ext_data_oe <= !cur_q.is_read && st_q != xgp_pkg::XGP_IDLE;
      ext_wr_strobe <= cfg_q[`XGP_CFG_RDWR] && !cur_q.is_read &&
        (st_q == xgp_pkg::XGP_STROBE || st_q == xgp_pkg::XGP_SECOND);
      ext_rd_strobe <= cfg_q[`XGP_CFG_RDWR] && cur_q.is_read &&
        (st_q == xgp_pkg::XGP_STROBE || st_q == xgp_pkg::XGP_SECOND);
    end
  end
endmodule
`default_nettype wire

// ### sim/xgp_port_properties.sv
// Purpose: bus and strobe checks on the port's pins
// Assumes: clk_en held high by the bench
// Notes: bound to xgp_port below
`timescale 1ns/100ps
`default_nettype none
module xgp_port_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_wr_strobe,
  input wire logic ext_rd_strobe,
  input wire logic ext_data_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_reset_idle: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !ext_wr_strobe && !ext_rd_strobe)
    else $error("outputs busy right after reset");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
    else $error("read response not okay");
  a_strobe_apart: assert property (!(ext_wr_strobe && ext_rd_strobe))
    else $error("read and write strobes together");
  a_oe_on_write: assert property (ext_wr_strobe |-> ext_data_oe)
    else $error("write strobe without data drive");
  a_oe_off_read: assert property (ext_rd_strobe |-> !ext_data_oe)
    else $error("data driven during read strobe");
endmodule
bind xgp_port xgp_port_properties u_props (.*);
`default_nettype wire

// ### sim/xgp_ext_model.sv
// Purpose: behavioural external peripheral
// Assumes: read data is a pattern of the address
// Notes: slow holds ready low for SLOW_CYC clocks of a strobe
`timescale 1ns/100ps
`default_nettype none
module xgp_ext_model #(
  parameter int SLOW_CYC = 40
) (
  input wire logic aclk,
  input wire logic slow,
  input wire logic [19:0] ext_addr,
  input wire logic [31:0] ext_data_out,
  input wire logic ext_rd_strobe,
  input wire logic ext_wr_strobe,
  output logic [31:0] ext_data_in,
  output logic peripheral_ready_in,
  output logic ext_clock_enable_in,
  output logic [19:0] wa,
  output logic [31:0] wd
);
  logic [31:0] last_q = 32'h0;
  logic [7:0] cnt_q = 8'h00;
  logic wr_q = 1'b0;
  // released bus shows the inverse, never a stale copy
  assign ext_data_in = ext_rd_strobe ? {12'hA50, ext_addr} : ~last_q;
  assign ext_clock_enable_in = 1'b1;
  always @(posedge aclk) begin
    if (ext_rd_strobe) last_q <= {12'hA50, ext_addr};
    wr_q <= ext_wr_strobe;
    if (ext_wr_strobe && !wr_q) begin
      wa <= ext_addr;
      wd <= ext_data_out;
    end
  end
  always @(posedge aclk) begin
    cnt_q <= (ext_rd_strobe || ext_wr_strobe) ? cnt_q + 8'h01 : 8'h00;
    peripheral_ready_in <= !slow || cnt_q >= SLOW_CYC;
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: self-checking bench for the external port
// Assumes: aclk 100 MHz, model answers with address patterns
// Notes: reset status first, then window table, write buffer, streams, stop
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, clk_en, map_valid, map_hit, slow;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ext_data_oe, ext_clk, ext_frame;
  logic ext_wr_strobe, ext_rd_strobe, peripheral_ready_in;
  logic ext_clock_enable_in, error_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] ext_addr, wa;
  logic [31:0] s_axi_wdata, s_axi_rdata, map_addr, ext_data_out;
  logic [31:0] ext_data_in, wd, d, v;
  int num_errors = 0;
  int checks_done = 0;
  // window setting, address, expected hit
  logic [40:0] rows [10] = '{{8'h04, 32'hA000_0000, 1'h1},
    {8'h04, 32'hA000_0100, 1'h0}, {8'h04, 32'hC000_0000, 1'h0},
    {8'h09, 32'hC000_FFFC, 1'h1}, {8'h09, 32'hC001_0000, 1'h0},
    {8'h60, 32'h60FF_FFFC, 1'h1}, {8'h60, 32'h6100_0000, 1'h0},
    {8'hB0, 32'h9FFF_FFFC, 1'h1}, {8'hB0, 32'hA000_0000, 1'h0},
    {8'h00, 32'hA000_0000, 1'h0}};
  xgp_port dut (.*);
  xgp_ext_model u_ext (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    x = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] x);
    logic [31:0] s;
    do rd(12'h018, s); while ((s & m) !== x);
  endtask
  task results;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    results;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, slow} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    {s_axi_wdata, map_addr} = 64'h0;
    {clk_en, map_valid, s_axi_wstrb} = 6'h3F;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h018, d);
    chk(d & 32'hF07, 32'h4);
    rd(12'h3FC, d);
    chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(12'h004, {24'h0, rows[i][40:33]});
      @(posedge aclk) map_addr <= rows[i][32:1];
      @(posedge aclk) chk(map_hit, rows[i][0]);
    end
    wr(12'h000, 32'h0000_0F25);
    rd(12'h000, d);
    chk(d, 32'h0000_0F25);
    chk(ext_frame, 32'h0);
    slow <= 1'b1;
    wr(12'h024, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(12'h020, 32'h40 + 32'(i));
      wr(12'h01C, 32'h1234_0000 + 32'(i));
    end
    rd(12'h028, d);
    chk(d & 32'h2, 32'h2);
    chk(error_irq, 32'h1);
    wr(12'h028, 32'h2);
    rd(12'h028, d);
    chk(d & 32'h2, 32'h0);
    chk(error_irq, 32'h0);
    slow <= 1'b0;
    poll(32'h7, 32'h4);
    // last popped write still needs setup and strobe on the bus
    repeat (40) @(posedge aclk);
    chk(wa, 32'h45);
    chk(wd, 32'h1234_0005);
    for (int s = 0; s < 3; s++) begin
      v = s == 0 ? 32'hFFFF_FFFF : s == 1 ? 32'hFFFF : 32'hFF;
      wr(12'h008, 32'h20 + 32'(4 * s));
      wr(12'h010, 32'h0002_0001 | 32'(s << 4));
      poll(32'hF00, 32'h200);
      rd(12'h00C, d);
      chk(d, 32'h0);
      for (int k = 0; k < 2; k++) begin
        rd(12'h014, d);
        chk(d, {12'hA50, 20'(32 + 4 * s + k)} & v);
      end
    end
    slow <= 1'b1;
    wr(12'h008, 32'h0);
    wr(12'h010, 32'h0008_0001);
    repeat (300) @(posedge aclk);
    wr(12'h010, 32'h2);
    repeat (100) @(posedge aclk);
    rd(12'h00C, v);
    repeat (300) @(posedge aclk);
    rd(12'h00C, d);
    chk(d, v);
    results;
  end
endmodule
`default_nettype wire
